// [core/usb_irq_flags.sv]
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module usb_irq_flags #(parameter int IDLE_CYCLES = usb_irq_pkg::IDLE_CYCLES)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic current_role,
  input wire logic id_pin,
  input wire logic ev_wakeup,
  input wire logic ev_session,
  input wire logic ev_disconnect,
  input wire logic ev_sof,
  input wire logic ev_iso_out_dropped,
  input wire logic ev_enum_done,
  input wire logic ev_bus_reset,
  input wire logic ev_suspend,
  input wire logic bus_idle,
  input wire logic [6:0] frame_pct,
  input wire logic [1:0] periodic_frame_end_time,
  input wire logic periodic_pending,
  input wire logic iso_out_pending,
  input wire logic iso_in_pending,
  input wire logic ptx_half_empty,
  input wire logic ptx_empty,
  input wire logic np_half_empty,
  input wire logic np_empty,
  input wire logic host_channels_pending,
  input wire logic host_port_pending,
  input wire logic out_endpoints_pending,
  input wire logic in_endpoints_pending,
  input wire logic otg_pending,
  input wire logic rx_fifo_nonempty,
  input wire logic set_out_nak_request,
  input wire logic set_in_nak_request,
  input wire logic clear_out_nak,
  input wire logic clear_in_nak,
  input wire logic out_nak_ready,
  input wire logic in_nak_ready,
  input wire logic reg_access,
  input wire logic reg_host_only,
  input wire logic reg_device_only,
  output logic access_refused,
  output logic frame_number_reset,
  output logic bus_clock_soft_reset,
  output logic core_soft_reset,
  output logic irq
);

  flag_bank_if #(.W(32)) fb ();

  logic [31:0] enables_r;
  logic [31:0] bus_ctrl_r;
  logic [2:0] rst_bits_r;
  logic [2:0] rst_cnt_r;
  usb_irq_pkg::rst_state_e rst_state_r;
  logic id_meta_r;
  logic id_sync_r;
  logic id_prev_r;
  logic [2:0] id_arm_r;
  logic [15:0] idle_cnt_r;
  logic eopf_seen_r;
  logic out_nak_pend_r;
  logic in_nak_pend_r;
  logic out_nak_eff_r;
  logic in_nak_eff_r;
  logic [31:0] set_vec;
  logic [31:0] live_vec;
  logic [31:0] flags_rd;
  logic [6:0] eopf_thr;
  logic eopf_hit;
  logic idle_hit;
  logic id_changed;
  logic frame_rst_fault;
  logic role_fault;
  logic wr_flags;
  logic wr_enables;
  logic wr_bus_ctrl;
  logic wr_reset;
  logic host;
  logic dev;

  sticky_flags #(.W(32)) flag_bank (
    .clk(clk),
    .rst_n(rst_n),
    .bus(fb.bank)
  );

  assign host = current_role;
  assign dev = !current_role;
  assign wr_flags = wr && (addr == usb_irq_pkg::FLAGS_OFS);
  assign wr_enables = wr && (addr == usb_irq_pkg::ENABLES_OFS);
  assign wr_bus_ctrl = wr && (addr == usb_irq_pkg::BUS_CTRL_OFS);
  assign wr_reset = wr && (addr == usb_irq_pkg::SOFT_RESET_OFS);

  // ****************************************
  // soft reset sequencer
  // ****************************************
  assign frame_rst_fault = wr_reset && wdata[usb_irq_pkg::FRAME_RST_BIT] && dev;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_state_r <= usb_irq_pkg::RST_IDLE;
      rst_bits_r <= 3'h0;
      rst_cnt_r <= 3'h0;
    end
    else
    begin
      case (rst_state_r)
        usb_irq_pkg::RST_IDLE:
        begin
          if (wr_reset && (wdata[2:0] & {host, 2'b11}) != 3'h0)
          begin
            rst_bits_r <= wdata[2:0] & {host, 2'b11};
            rst_cnt_r <= 3'h0;
            rst_state_r <= usb_irq_pkg::RST_HOLD;
          end
        end
        usb_irq_pkg::RST_HOLD:
        begin
          // further writes are ignored while busy
          rst_cnt_r <= rst_cnt_r + 3'h1;
          if (rst_cnt_r == usb_irq_pkg::SOFT_RESET_HOLD - 3'h1)
          begin
            rst_state_r <= usb_irq_pkg::RST_DONE;
          end
        end
        usb_irq_pkg::RST_DONE:
        begin
          rst_bits_r <= 3'h0;
          rst_state_r <= usb_irq_pkg::RST_IDLE;
        end
        default:
        begin
          rst_bits_r <= 3'h0;
          rst_state_r <= usb_irq_pkg::RST_IDLE;
        end
      endcase
    end
  end

  assign frame_number_reset = rst_bits_r[usb_irq_pkg::FRAME_RST_BIT];
  assign bus_clock_soft_reset = rst_bits_r[usb_irq_pkg::BUS_RST_BIT] |
    rst_bits_r[usb_irq_pkg::CORE_RST_BIT];
  assign core_soft_reset = rst_bits_r[usb_irq_pkg::CORE_RST_BIT];

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enables_r <= usb_irq_pkg::ENABLES_RESET;
    end
    else if (core_soft_reset)
    begin
      enables_r <= usb_irq_pkg::ENABLES_RESET;
    end
    else if (wr_enables)
    begin
      enables_r <= wdata & usb_irq_pkg::ENABLE_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_ctrl_r <= usb_irq_pkg::BUS_CTRL_RESET;
    end
    else if (core_soft_reset)
    begin
      bus_ctrl_r <= usb_irq_pkg::BUS_CTRL_RESET;
    end
    else if (wr_bus_ctrl)
    begin
      bus_ctrl_r <= wdata & usb_irq_pkg::BUS_CTRL_MASK;
    end
  end

  // ****************************************
  // id pin synchroniser and change detect
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      id_meta_r <= 1'b0;
      id_sync_r <= 1'b0;
      id_prev_r <= 1'b0;
      id_arm_r <= 3'h0;
    end
    else
    begin
      id_meta_r <= id_pin;
      id_sync_r <= id_meta_r;
      id_prev_r <= id_sync_r;
      id_arm_r <= {id_arm_r[1:0], 1'b1};
    end
  end

  assign id_changed = id_arm_r[2] && (id_sync_r != id_prev_r);

  // ****************************************
  // bus idle timer
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idle_cnt_r <= 16'h0000;
    end
    else if (!bus_idle || host || bus_clock_soft_reset)
    begin
      idle_cnt_r <= 16'h0000;
    end
    else if (idle_cnt_r != 16'(IDLE_CYCLES))
    begin
      idle_cnt_r <= idle_cnt_r + 16'h0001;
    end
  end

  assign idle_hit = bus_idle && dev && (idle_cnt_r == 16'(IDLE_CYCLES - 1));

  // ****************************************
  // end of periodic frame detect
  // ****************************************
  assign eopf_thr = usb_irq_pkg::EOPF_BASE_PCT +
    7'(usb_irq_pkg::EOPF_STEP_PCT * periodic_frame_end_time);
  assign eopf_hit = dev && (frame_pct >= eopf_thr) && !eopf_seen_r;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eopf_seen_r <= 1'b0;
    end
    else
    begin
      eopf_seen_r <= dev && (frame_pct >= eopf_thr);
    end
  end

  // ****************************************
  // global NAK effective tracking
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_nak_pend_r <= 1'b0;
      out_nak_eff_r <= 1'b0;
    end
    else if (bus_clock_soft_reset || host)
    begin
      out_nak_pend_r <= 1'b0;
      out_nak_eff_r <= 1'b0;
    end
    else
    begin
      if (set_out_nak_request)
      begin
        out_nak_pend_r <= 1'b1;
      end
      else if (out_nak_pend_r && out_nak_ready)
      begin
        out_nak_pend_r <= 1'b0;
      end
      if (out_nak_pend_r && out_nak_ready)
      begin
        out_nak_eff_r <= 1'b1;
      end
      else if (clear_out_nak)
      begin
        out_nak_eff_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_nak_pend_r <= 1'b0;
      in_nak_eff_r <= 1'b0;
    end
    else if (bus_clock_soft_reset || host)
    begin
      in_nak_pend_r <= 1'b0;
      in_nak_eff_r <= 1'b0;
    end
    else
    begin
      if (set_in_nak_request)
      begin
        in_nak_pend_r <= 1'b1;
      end
      else if (in_nak_pend_r && in_nak_ready)
      begin
        in_nak_pend_r <= 1'b0;
      end
      if (in_nak_pend_r && in_nak_ready)
      begin
        in_nak_eff_r <= 1'b1;
      end
      else if (clear_in_nak)
      begin
        in_nak_eff_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // flag sources
  // ****************************************
  assign role_fault = reg_access && ((reg_host_only && dev) || (reg_device_only && host));
  assign access_refused = role_fault;

  always_comb
  begin
    set_vec = usb_irq_pkg::ZERO_WORD;
    set_vec[usb_irq_pkg::WAKEUP_BIT] = ev_wakeup;
    set_vec[usb_irq_pkg::SESSION_BIT] = ev_session;
    set_vec[usb_irq_pkg::DISCONNECT_BIT] = ev_disconnect && host;
    set_vec[usb_irq_pkg::ID_CHANGE_BIT] = id_changed;
    set_vec[usb_irq_pkg::PERIODIC_INC_BIT] = (host && ev_sof && periodic_pending) ||
      (eopf_hit && iso_out_pending);
    set_vec[usb_irq_pkg::ISO_IN_INC_BIT] = eopf_hit && iso_in_pending;
    set_vec[usb_irq_pkg::EOPF_BIT] = eopf_hit;
    set_vec[usb_irq_pkg::ISO_DROP_BIT] = dev && ev_iso_out_dropped;
    set_vec[usb_irq_pkg::ENUM_DONE_BIT] = dev && ev_enum_done;
    set_vec[usb_irq_pkg::BUS_RESET_BIT] = dev && ev_bus_reset;
    set_vec[usb_irq_pkg::SUSPEND_BIT] = dev && ev_suspend;
    set_vec[usb_irq_pkg::EARLY_SUSPEND_BIT] = idle_hit;
    set_vec[usb_irq_pkg::SOF_BIT] = ev_sof;
    set_vec[usb_irq_pkg::MODE_FAULT_BIT] = role_fault || frame_rst_fault;
  end

  assign fb.set = set_vec;
  assign fb.clr = wr_flags ? (wdata & usb_irq_pkg::STICKY_MASK) : usb_irq_pkg::ZERO_WORD;
  assign fb.flush = bus_clock_soft_reset;

  always_comb
  begin
    live_vec = usb_irq_pkg::ZERO_WORD;
    live_vec[usb_irq_pkg::PTX_EMPTY_BIT] = host &&
      (bus_ctrl_r[usb_irq_pkg::PTX_THRESH_BIT] ? ptx_empty : ptx_half_empty);
    live_vec[usb_irq_pkg::NP_EMPTY_BIT] = host &&
      (bus_ctrl_r[usb_irq_pkg::NP_THRESH_BIT] ? np_empty : np_half_empty);
    live_vec[usb_irq_pkg::HOST_CH_BIT] = host && host_channels_pending;
    live_vec[usb_irq_pkg::HOST_PORT_BIT] = host && host_port_pending;
    live_vec[usb_irq_pkg::OUT_EP_BIT] = dev && out_endpoints_pending;
    live_vec[usb_irq_pkg::IN_EP_BIT] = dev && in_endpoints_pending;
    live_vec[usb_irq_pkg::OTG_BIT] = otg_pending;
    live_vec[usb_irq_pkg::OUT_NAK_BIT] = out_nak_eff_r;
    live_vec[usb_irq_pkg::IN_NAK_BIT] = in_nak_eff_r;
    live_vec[usb_irq_pkg::RX_NONEMPTY_BIT] = rx_fifo_nonempty;
    live_vec[usb_irq_pkg::ROLE_BIT] = current_role;
  end

  assign flags_rd = (fb.value & usb_irq_pkg::STICKY_MASK) | live_vec;

  // ****************************************
  // interrupt output
  // ****************************************
  assign irq = bus_ctrl_r[usb_irq_pkg::MASTER_EN_BIT] && ((flags_rd & enables_r) != 32'h0);

  // ****************************************
  // read data, one cycle after the strobe
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata <= usb_irq_pkg::ZERO_WORD;
    end
    else if (rd)
    begin
      case (addr)
        usb_irq_pkg::BUS_CTRL_OFS: rdata <= bus_ctrl_r;
        usb_irq_pkg::SOFT_RESET_OFS: rdata <= {(rst_state_r == usb_irq_pkg::RST_IDLE),
          28'h0000000, rst_bits_r};
        usb_irq_pkg::FLAGS_OFS: rdata <= flags_rd;
        usb_irq_pkg::ENABLES_OFS: rdata <= enables_r;
        default: rdata <= usb_irq_pkg::ZERO_WORD;
      endcase
    end
    else
    begin
      rdata <= usb_irq_pkg::ZERO_WORD;
    end
  end

endmodule : usb_irq_flags

// [core/usb_irq_pkg.sv]
package usb_irq_pkg;

  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0] BUS_CTRL_OFS = 8'h08;
  localparam logic [7:0] SOFT_RESET_OFS = 8'h10;
  localparam logic [7:0] FLAGS_OFS = 8'h14;
  localparam logic [7:0] ENABLES_OFS = 8'h18;
  localparam logic [31:0] FLAGS_RESET = 32'h04000021;
  localparam logic [31:0] ENABLES_RESET = 32'h00000000;
  localparam logic [31:0] BUS_CTRL_RESET = 32'h00000000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;

  // ****************************************
  // field layouts
  // ****************************************
  localparam logic [31:0] ENABLE_MASK = 32'hF73CFCFE;
  localparam logic [31:0] STICKY_MASK = 32'hF030FC0A;
  localparam logic [31:0] BUS_CTRL_MASK = 32'h00000181;
  localparam int WAKEUP_BIT = 31;
  localparam int SESSION_BIT = 30;
  localparam int DISCONNECT_BIT = 29;
  localparam int ID_CHANGE_BIT = 28;
  localparam int PTX_EMPTY_BIT = 26;
  localparam int HOST_CH_BIT = 25;
  localparam int HOST_PORT_BIT = 24;
  localparam int PERIODIC_INC_BIT = 21;
  localparam int ISO_IN_INC_BIT = 20;
  localparam int OUT_EP_BIT = 19;
  localparam int IN_EP_BIT = 18;
  localparam int EOPF_BIT = 15;
  localparam int ISO_DROP_BIT = 14;
  localparam int ENUM_DONE_BIT = 13;
  localparam int BUS_RESET_BIT = 12;
  localparam int SUSPEND_BIT = 11;
  localparam int EARLY_SUSPEND_BIT = 10;
  localparam int OUT_NAK_BIT = 7;
  localparam int IN_NAK_BIT = 6;
  localparam int NP_EMPTY_BIT = 5;
  localparam int RX_NONEMPTY_BIT = 4;
  localparam int SOF_BIT = 3;
  localparam int OTG_BIT = 2;
  localparam int MODE_FAULT_BIT = 1;
  localparam int ROLE_BIT = 0;
  localparam int PTX_THRESH_BIT = 8;
  localparam int NP_THRESH_BIT = 7;
  localparam int MASTER_EN_BIT = 0;
  localparam int FRAME_RST_BIT = 2;
  localparam int BUS_RST_BIT = 1;
  localparam int CORE_RST_BIT = 0;
  localparam int RESET_IDLE_BIT = 31;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int IDLE_TIME_US = 3000;
  localparam int IDLE_CYCLES = (IDLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SOFT_RESET_HOLD = 3'h4;
  localparam logic [6:0] EOPF_BASE_PCT = 7'h50;
  localparam logic [6:0] EOPF_STEP_PCT = 7'h05;

  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_HOLD = 2'b01,
    RST_DONE = 2'b10
  } rst_state_e;

endpackage : usb_irq_pkg

// [core/flag_bank_if.sv]
`timescale 1ns/1ps
interface flag_bank_if #(parameter int W = 32);
  logic [W-1:0] set;
  logic [W-1:0] clr;
  logic flush;
  logic [W-1:0] value;
  modport owner (output set, output clr, output flush, input value);
  modport bank (input set, input clr, input flush, output value);
endinterface : flag_bank_if

// [core/sticky_flags.sv]
`timescale 1ns/1ps
module sticky_flags #(parameter int W = 32)
(
  input wire logic clk,
  input wire logic rst_n,
  flag_bank_if.bank bus
);

  logic [W-1:0] flags_r;

  // ****************************************
  // sticky bits, a set in the clear cycle wins
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_r <= '0;
    end
    else if (bus.flush)
    begin
      flags_r <= bus.set;
    end
    else
    begin
      flags_r <= (flags_r & ~bus.clr) | bus.set;
    end
  end

  assign bus.value = flags_r;

endmodule : sticky_flags

// [verification/usb_sw_model.sv]
`timescale 1ns/1ps
module usb_sw_model (
  input wire logic clk,
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [31:0] rdata
);
  // ****************************************
  // software side of the register port
  // ****************************************
  initial
  begin
    addr = 8'h00;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
  end

  task automatic write(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask : read

  // no other access until the self-clearing reset bits drop
  task automatic wait_reset_clear(output logic [31:0] v);
    v = 32'h00000007;
    for (int n = 0; n < 20 && v[2:0] != 3'h0; n++)
      read(usb_irq_pkg::SOFT_RESET_OFS, v);
  endtask : wait_reset_clear
endmodule : usb_sw_model

// [verification/usb_irq_flags_props.sv]
`timescale 1ns/1ps
module usb_irq_flags_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic current_role,
  input wire logic ev_wakeup,
  input wire logic ev_sof,
  input wire logic otg_pending,
  input wire logic rx_fifo_nonempty,
  input wire logic reg_access,
  input wire logic reg_host_only,
  input wire logic reg_device_only,
  input wire logic access_refused,
  input wire logic frame_number_reset,
  input wire logic bus_clock_soft_reset,
  input wire logic core_soft_reset,
  input wire logic irq
);
  // ****************************************
  // port relations
  // ****************************************
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire rd_flags = rd && addr == usb_irq_pkg::FLAGS_OFS;

  a_refuse_wrong_role: assert property (access_refused == (reg_access && ((current_role &&
    reg_device_only) || (!current_role && reg_host_only)))) else $error("refusal mismatch");
  a_frame_rst_device: assert property (wr && addr == usb_irq_pkg::SOFT_RESET_OFS && wdata[2]
    && !current_role && !frame_number_reset |=> !frame_number_reset) else $error("frame reset in device");
  a_frame_rst_host: assert property ($rose(frame_number_reset) |-> $past(current_role)
    ##[1:8] !frame_number_reset) else $error("frame reset not host or stuck");
  a_bus_rst_hold: assert property ($rose(bus_clock_soft_reset) |-> bus_clock_soft_reset[*4]
    ##[1:2] !bus_clock_soft_reset) else $error("bus clock reset length");
  a_core_rst_hold: assert property ($rose(core_soft_reset) |-> core_soft_reset[*4]
    ##[1:2] !core_soft_reset) else $error("core reset length");
  a_core_rst_irq: assert property (core_soft_reset |=> !irq) else $error("irq during core reset");
  a_wakeup_seen: assert property (ev_wakeup ##[1:3] rd_flags |=> rdata[31])
    else $error("wakeup flag missing");
  a_sof_seen: assert property (ev_sof ##[1:3] rd_flags |=> rdata[3]) else $error("sof flag missing");
  a_live_mirror: assert property (rd_flags |=> {rdata[4], rdata[2]} ==
    $past({rx_fifo_nonempty, otg_pending})) else $error("live flags wrong");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == usb_irq_pkg::ZERO_WORD)
    else $error("read data outside read slot");

  c_wakeup: cover property (ev_wakeup);
  c_refused: cover property (access_refused);
  c_irq: cover property ($rose(irq));
  c_bus_rst: cover property ($fell(bus_clock_soft_reset));
endmodule : usb_irq_flags_props

bind usb_irq_flags usb_irq_flags_props u_props (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .current_role(current_role),
  .ev_wakeup(ev_wakeup), .ev_sof(ev_sof), .otg_pending(otg_pending),
  .rx_fifo_nonempty(rx_fifo_nonempty), .reg_access(reg_access), .reg_host_only(reg_host_only),
  .reg_device_only(reg_device_only), .access_refused(access_refused),
  .frame_number_reset(frame_number_reset), .bus_clock_soft_reset(bus_clock_soft_reset),
  .core_soft_reset(core_soft_reset), .irq(irq));

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
  // ****************************************
  // stimulus and model state
  // ****************************************
  localparam int IDLE = 20;
  logic clk = 1'b0, rst_n = 1'b0, wr, rd, irq, refused, frst, brst, crst;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, d, sticky = '0, en = '0, ctl = '0;
  logic role = 1'b1, id_pin = 1'b0, bus_idle = 1'b0, ppend = 1'b0, iso_o = 1'b0, iso_i = 1'b0;
  logic [11:0] pls = '0;
  logic [1:0] rdy = '0, eft = '0;
  logic [3:0] fifo = 4'hF;
  logic [5:0] live = '0;
  logic [2:0] racc = '0;
  logic [6:0] pct = '0;
  int errors = 0, checked = 0, cycles = 0, seed = 87019;
  int ev_bit[8] = '{31, 30, 29, 3, 14, 13, 12, 11};

  usb_irq_flags #(.IDLE_CYCLES(IDLE)) uut (.clk, .rst_n, .addr, .wdata, .wr, .rd, .rdata,
    .current_role(role), .id_pin, .ev_wakeup(pls[0]), .ev_session(pls[1]),
    .ev_disconnect(pls[2]), .ev_sof(pls[3]), .ev_iso_out_dropped(pls[4]),
    .ev_enum_done(pls[5]), .ev_bus_reset(pls[6]), .ev_suspend(pls[7]), .bus_idle,
    .frame_pct(pct), .periodic_frame_end_time(eft), .periodic_pending(ppend),
    .iso_out_pending(iso_o), .iso_in_pending(iso_i), .ptx_half_empty(fifo[3]),
    .ptx_empty(fifo[2]), .np_half_empty(fifo[1]), .np_empty(fifo[0]),
    .host_channels_pending(live[5]), .host_port_pending(live[4]),
    .out_endpoints_pending(live[3]), .in_endpoints_pending(live[2]), .otg_pending(live[1]),
    .rx_fifo_nonempty(live[0]), .set_out_nak_request(pls[8]), .set_in_nak_request(pls[9]),
    .clear_out_nak(pls[10]), .clear_in_nak(pls[11]), .out_nak_ready(rdy[1]),
    .in_nak_ready(rdy[0]), .reg_access(racc[2]), .reg_host_only(racc[1]),
    .reg_device_only(racc[0]), .access_refused(refused), .frame_number_reset(frst),
    .bus_clock_soft_reset(brst), .core_soft_reset(crst), .irq);
  usb_sw_model sw (.clk, .addr, .wdata, .wr, .rd, .rdata);

  // ****************************************
  // model, compare and bus helpers
  // ****************************************
  function automatic logic [31:0] exp_flags();
    logic [31:0] f;
    f = sticky;
    f[0] = role;
    {f[25], f[24], f[19], f[18], f[2], f[4]} = live;
    // host channel and port summaries only in host mode, endpoint summaries only as device
    f[25] = role & live[5];
    f[24] = role & live[4];
    f[19] = ~role & live[3];
    f[18] = ~role & live[2];
    f[26] = role & (ctl[8] ? fifo[2] : fifo[3]);
    f[5] = role & (ctl[7] ? fifo[0] : fifo[1]);
    return f;
  endfunction : exp_flags

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    sw.write(a, v);
    if (a == usb_irq_pkg::FLAGS_OFS) sticky &= ~(v & 32'hF030FC0A);
    if (a == usb_irq_pkg::ENABLES_OFS) en = v & 32'hF73CFCFE;
    if (a == usb_irq_pkg::BUS_CTRL_OFS) ctl = v & 32'h00000181;
  endtask : wreg

  task automatic chk();
    sw.read(usb_irq_pkg::FLAGS_OFS, d);
    check(d, exp_flags());
    #1;
    check({31'h0, irq}, {31'h0, ctl[0] & |(exp_flags() & en)});
  endtask : chk

  task automatic pulse(input int i);
    @(posedge clk);
    pls[i] <= 1'b1;
    @(posedge clk);
    pls[i] <= 1'b0;
  endtask : pulse

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // ****************************************
  // clock, watchdog and sequence
  // ****************************************
  always #50 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      errors++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk();
    check(d, 32'h04000021);
    sw.read(usb_irq_pkg::ENABLES_OFS, d);
    check(d, 32'h00000000);
    wreg(8'h40, 32'hFFFFFFFF);
    sw.read(8'h40, d);
    check(d, 32'h00000000);
    wreg(usb_irq_pkg::ENABLES_OFS, 32'hFFFFFFFF);
    sw.read(usb_irq_pkg::ENABLES_OFS, d);
    check(d, 32'hF73CFCFE);
    wreg(usb_irq_pkg::ENABLES_OFS, 32'h00000000);
    wreg(usb_irq_pkg::BUS_CTRL_OFS, 32'h00000001);
    for (int r = 1; r >= 0; r--)
    begin
      @(posedge clk);
      role <= r[0];
      for (int i = 0; i < 8; i++)
      begin
        if (r == 1 ? i > 3 : i < 3) continue;
        ppend <= 1'($random(seed));
        pulse(i);
        sticky[ev_bit[i]] = 1'b1;
        if (i == 3 && r == 1 && ppend) sticky[21] = 1'b1;
        chk();
        wreg(usb_irq_pkg::ENABLES_OFS, 32'h1 << ev_bit[i]);
        chk();
        wreg(usb_irq_pkg::FLAGS_OFS, sticky);
        chk();
      end
      ppend <= 1'b0;
    end
    @(posedge clk);
    role <= 1'b1;
    wreg(usb_irq_pkg::ENABLES_OFS, 32'h070C0034);
    for (int k = 0; k < 8; k++)
    begin
      wreg(usb_irq_pkg::BUS_CTRL_OFS, 32'((k % 4) << 7) | 32'(k / 4));
      fifo <= 4'($random(seed));
      live <= 6'($random(seed));
      repeat (2) @(posedge clk);
      chk();
    end
    live <= '0;
    fifo <= 4'hF;
    repeat (2) @(posedge clk);
    chk();
    @(posedge clk);
    racc <= 3'b101;
    #1 check({31'h0, refused}, 32'h1);
    @(posedge clk);
    racc <= 3'b110;
    #1 check({31'h0, refused}, 32'h0);
    @(posedge clk);
    racc <= '0;
    sticky[1] = 1'b1;
    chk();
    for (int b = 2; b >= 0; b--)
    begin
      pulse(0);
      sticky[31] = 1'b1;
      wreg(usb_irq_pkg::SOFT_RESET_OFS, 32'h1 << b);
      // core reset also holds the bus clock domain in reset
      #1 check({29'h0, frst, brst, crst}, (32'h1 << b) | (b == 0 ? 32'h2 : 32'h0));
      sw.wait_reset_clear(d);
      check(d, 32'h80000000);
      if (b < 2) sticky = '0;
      if (b == 0) en = '0;
      if (b == 0) ctl = '0;
      chk();
      wreg(usb_irq_pkg::FLAGS_OFS, sticky);
    end
    @(posedge clk);
    role <= 1'b0;
    sticky[1] = 1'b1;
    wreg(usb_irq_pkg::SOFT_RESET_OFS, 32'h00000004);
    #1 check({31'h0, frst}, 32'h0);
    chk();
    for (int s = 0; s < 4; s++)
    begin
      eft <= 2'(s);
      iso_o <= 1'($random(seed));
      iso_i <= 1'($random(seed));
      pct <= 7'(79 + 5 * s);
      repeat (2) @(posedge clk);
      chk();
      pct <= 7'(80 + 5 * s);
      repeat (2) @(posedge clk);
      sticky[15] = 1'b1;
      sticky[21] = iso_o;
      sticky[20] = iso_i;
      chk();
      pct <= '0;
      wreg(usb_irq_pkg::FLAGS_OFS, sticky);
    end
    bus_idle <= 1'b1;
    repeat (IDLE / 2) @(posedge clk);
    chk();
    repeat (IDLE) @(posedge clk);
    sticky[10] = 1'b1;
    chk();
    bus_idle <= 1'b0;
    wreg(usb_irq_pkg::FLAGS_OFS, sticky);
    for (int k = 0; k < 2; k++)
    begin
      pulse(8 + k);
      repeat (3) @(posedge clk);
      chk();
      rdy[1 - k] <= 1'b1;
      repeat (3) @(posedge clk);
      sticky[7 - k] = 1'b1;
      chk();
      rdy <= '0;
      pulse(10 + k);
      repeat (2) @(posedge clk);
      sticky[7 - k] = 1'b0;
      chk();
    end
    id_pin <= 1'b1;
    repeat (6) @(posedge clk);
    sticky[28] = 1'b1;
    chk();
    report_and_stop();
  end
endmodule : tb
